// ### include/lppg_pkg.sv
// lppg_pkg: modes, requests, register map and output bundle of the
// low-power peripheral gating block.
// assumes an 8-bit register port and sixteen gated peripheral clocks.
package lppg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_PERIPH = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_GATE_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GATE_TWO = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_SRC_ONE = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_SRC_TWO = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_PWR_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE_STAT = 8'h05;

  // clk_source_ctrl_one fields
  localparam int BIT_IREF_STOP = 0;
  localparam int BIT_IREF_CLK = 1;
  // clk_source_ctrl_two fields
  localparam int BIT_EREF_STOP = 0;
  localparam int BIT_EREF_CLK = 1;
  localparam int BIT_BYP_LP = 2;
  // power control fields
  localparam int BIT_LVD_EN = 0;
  localparam int BIT_LV_STOP = 1;
  localparam int BIT_DEEP_STOP = 2;
  // mode status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_DBG = 3;
  localparam int STAT_SUBST = 4;

  // reset values
  localparam logic [DATA_W-1:0] RST_GATE_ONE = 8'hff;
  localparam logic [DATA_W-1:0] RST_GATE_TWO = 8'hff;
  localparam logic [DATA_W-1:0] RST_SRC_ONE = 8'h02;
  localparam logic [DATA_W-1:0] RST_SRC_TWO = 8'h00;
  localparam logic [DATA_W-1:0] RST_PWR_CTRL = 8'h01;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_LOWPOWER_RUN,
    MODE_LOWPOWER_WAIT,
    MODE_STANDBY_STOP,
    MODE_PARTIAL_POWERDOWN_STOP
  } lppg_mode_t;

  typedef enum logic [1:0] {
    REQ_WAIT,
    REQ_STOP,
    REQ_LOWPOWER_RUN,
    REQ_RUN
  } lppg_req_t;

  typedef enum logic [1:0] {
    SRC_ON,
    SRC_STANDBY,
    SRC_OFF
  } lppg_src_state_t;

  typedef enum logic [1:0] {
    VREG_FULL,
    VREG_STANDBY,
    VREG_PARTIAL
  } lppg_vreg_state_t;

  typedef struct packed {
    logic [NUM_PERIPH-1:0] periph_clk_en;
    logic cpu_clk_en;
    logic bdm_clk_en;
    lppg_src_state_t ics_state;
    logic xosc_run;
    lppg_vreg_state_t vreg_state;
    logic adc_async_only;
    logic adc_conv_ok;
    logic adc_bandgap_ok;
    logic analog_comparator_bandgap_ok;
    logic pin_hold;
    logic core_power_down;
  } lppg_pwr_out_t;

  function automatic logic is_stop(input lppg_mode_t m);
    return (m == MODE_STANDBY_STOP) || (m == MODE_PARTIAL_POWERDOWN_STOP);
  endfunction : is_stop

  function automatic logic is_lowpower(input lppg_mode_t m);
    return (m == MODE_LOWPOWER_RUN) || (m == MODE_LOWPOWER_WAIT);
  endfunction : is_lowpower

endpackage : lppg_pkg

// ### verilog/lppg_clk_gate.sv
// lppg_clk_gate: per-peripheral clock enables from the mode and the
// two clock-gating control registers.
// assumes the caller registers the result; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module lppg_clk_gate
  import lppg_pkg::*;
#(
  parameter int N = NUM_PERIPH
) (
  input wire lppg_pkg::lppg_mode_t i_mode,
  input wire logic [N-1:0] i_gate_bits,
  output logic [N-1:0] o_clk_en
);
  import lppg_pkg::*;

  logic stop_now;

  assign stop_now = is_stop(i_mode);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_gate
      // any stop halts every peripheral clock; else the gate bit rules
      assign o_clk_en[g] = !stop_now && i_gate_bits[g];
    end
  endgenerate

endmodule : lppg_clk_gate
`default_nettype wire

// ### verilog/lppg_mode_ctrl.sv
// lppg_mode_ctrl: power-mode control and peripheral clock gating.
// assumes a synchronous 8-bit register port and one-cycle mode requests
// from the core; all inputs except i_arst_n are synchronous to i_core_clk.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module lppg_mode_ctrl (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [lppg_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [lppg_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [lppg_pkg::DATA_W-1:0] o_reg_rdata,
  input wire logic i_req_valid,
  input wire lppg_pkg::lppg_req_t i_req_kind,
  input wire logic i_wake_irq,
  input wire logic i_reset_pin_low,
  input wire logic i_debug_mode_enable,
  output lppg_pkg::lppg_mode_t o_mode,
  output lppg_pkg::lppg_pwr_out_t o_pwr
);
  import lppg_pkg::*;

  typedef struct packed {
    lppg_mode_t mode;
    logic resume_lp;
    logic subst;
    logic [DATA_W-1:0] gate_one;
    logic [DATA_W-1:0] gate_two;
    logic [DATA_W-1:0] src_one;
    logic [DATA_W-1:0] src_two;
    logic [DATA_W-1:0] pwr_ctrl;
    logic [DATA_W-1:0] rdata;
    lppg_pwr_out_t out;
  } lppg_ctrl_state_t;

  lppg_ctrl_state_t q;
  lppg_ctrl_state_t d;

  logic [NUM_PERIPH-1:0] gate_en;

  // decoded configuration bits
  logic iref_clk;
  logic iref_stop;
  logic eref_clk;
  logic eref_stop;
  logic byp_lp;
  logic lvd_en;
  logic lv_stop;
  logic deep_stop;
  logic dbg;
  logic lp_blocked;
  logic in_stop;
  logic in_lp;
  logic cpu_awake;

  assign iref_clk = q.src_one[BIT_IREF_CLK];
  assign iref_stop = q.src_one[BIT_IREF_STOP];
  assign eref_clk = q.src_two[BIT_EREF_CLK];
  assign eref_stop = q.src_two[BIT_EREF_STOP];
  assign byp_lp = q.src_two[BIT_BYP_LP];
  assign lvd_en = q.pwr_ctrl[BIT_LVD_EN];
  assign lv_stop = q.pwr_ctrl[BIT_LV_STOP];
  assign deep_stop = q.pwr_ctrl[BIT_DEEP_STOP];
  assign dbg = i_debug_mode_enable;

  // debug or low-voltage stop forbid the lighter-power variants
  assign lp_blocked = dbg || lv_stop;

  assign in_stop = is_stop(q.mode);
  assign in_lp = is_lowpower(q.mode);
  assign cpu_awake = (q.mode == MODE_RUN) || (q.mode == MODE_LOWPOWER_RUN);

  lppg_clk_gate #(
    .N(NUM_PERIPH)
  ) u_clk_gate (
    .i_mode(q.mode),
    .i_gate_bits({q.gate_two, q.gate_one}),
    .o_clk_en(gate_en)
  );

  function automatic logic [DATA_W-1:0] read_mux(
    input logic [ADDR_W-1:0] a,
    input lppg_ctrl_state_t s,
    input logic dbg_bit
  );
    logic [DATA_W-1:0] r;
    r = '0;
    case (a)
      OFS_GATE_ONE: r = s.gate_one;
      OFS_GATE_TWO: r = s.gate_two;
      OFS_SRC_ONE: r = s.src_one;
      OFS_SRC_TWO: r = s.src_two;
      OFS_PWR_CTRL: r = s.pwr_ctrl;
      OFS_MODE_STAT: begin
        r[STAT_MODE_LSB +: 3] = s.mode;
        r[STAT_DBG] = dbg_bit;
        r[STAT_SUBST] = s.subst;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : read_mux

  always_comb begin
    d = q;

    // register port: read data only in the cycle after the strobe
    d.rdata = '0;
    if (i_reg_rd) begin
      d.rdata = read_mux(i_reg_addr, q, dbg);
    end

    if (i_reg_wr) begin
      case (i_reg_addr)
        OFS_GATE_ONE: d.gate_one = i_reg_wdata;
        OFS_GATE_TWO: d.gate_two = i_reg_wdata;
        OFS_SRC_ONE: d.src_one = i_reg_wdata;
        OFS_SRC_TWO: d.src_two = i_reg_wdata;
        OFS_PWR_CTRL: d.pwr_ctrl = i_reg_wdata;
        default: d.subst = q.subst;
      endcase
    end

    // mode sequencing
    case (q.mode)
      MODE_RUN: begin
        if (i_req_valid) begin
          case (i_req_kind)
            REQ_WAIT: begin
              d.mode = MODE_WAIT;
              d.subst = 1'b0;
            end
            REQ_STOP: begin
              d.resume_lp = 1'b0;
              if (deep_stop && !lp_blocked) begin
                d.mode = MODE_PARTIAL_POWERDOWN_STOP;
                d.subst = 1'b0;
              end else begin
                d.mode = MODE_STANDBY_STOP;
                d.subst = deep_stop;
              end
            end
            REQ_LOWPOWER_RUN: begin
              // clock source must already be in bypassed low-power mode
              if (lp_blocked) begin
                d.mode = MODE_RUN;
                d.subst = 1'b1;
              end else if (byp_lp) begin
                d.mode = MODE_LOWPOWER_RUN;
                d.subst = 1'b0;
              end else begin
                d.mode = MODE_RUN;
              end
            end
            default: d.mode = MODE_RUN;
          endcase
        end
      end
      MODE_LOWPOWER_RUN: begin
        if (i_req_valid) begin
          case (i_req_kind)
            REQ_WAIT: begin
              if (lp_blocked) begin
                d.mode = MODE_WAIT;
                d.subst = 1'b1;
              end else begin
                d.mode = MODE_LOWPOWER_WAIT;
                d.subst = 1'b0;
              end
            end
            REQ_STOP: begin
              // partial powerdown is not reachable from low-power run
              d.mode = MODE_STANDBY_STOP;
              d.resume_lp = 1'b1;
              d.subst = 1'b0;
            end
            REQ_RUN: d.mode = MODE_RUN;
            default: d.mode = MODE_LOWPOWER_RUN;
          endcase
        end
      end
      MODE_WAIT: begin
        if (i_wake_irq) begin
          d.mode = MODE_RUN;
        end
      end
      MODE_LOWPOWER_WAIT: begin
        if (i_wake_irq) begin
          d.mode = MODE_LOWPOWER_RUN;
        end
      end
      MODE_STANDBY_STOP: begin
        if (i_wake_irq) begin
          d.mode = q.resume_lp ? MODE_LOWPOWER_RUN : MODE_RUN;
          d.resume_lp = 1'b0;
        end
      end
      MODE_PARTIAL_POWERDOWN_STOP: begin
        // interrupts cannot wake this mode, only the reset pin
        if (i_reset_pin_low) begin
          d.mode = MODE_RUN;
        end
      end
      default: d.mode = MODE_RUN;
    endcase

    // power outputs, registered from the present mode
    d.out.periph_clk_en = gate_en;

    d.out.cpu_clk_en = cpu_awake;

    // debug logic keeps its clock in stop; powered down in partial stop
    d.out.bdm_clk_en = dbg && (q.mode != MODE_PARTIAL_POWERDOWN_STOP);

    case (q.mode)
      MODE_PARTIAL_POWERDOWN_STOP: d.out.ics_state = SRC_OFF;
      MODE_STANDBY_STOP: begin
        if (iref_clk && iref_stop) begin
          d.out.ics_state = SRC_ON;
        end else begin
          d.out.ics_state = SRC_STANDBY;
        end
      end
      default: d.out.ics_state = SRC_ON;
    endcase

    if (in_stop) begin
      d.out.xosc_run = eref_clk && eref_stop;
    end else begin
      d.out.xosc_run = eref_clk;
    end

    case (q.mode)
      MODE_PARTIAL_POWERDOWN_STOP: d.out.vreg_state = VREG_PARTIAL;
      MODE_STANDBY_STOP: begin
        d.out.vreg_state = lvd_en ? VREG_FULL : VREG_STANDBY;
      end
      MODE_LOWPOWER_RUN: d.out.vreg_state = VREG_STANDBY;
      MODE_LOWPOWER_WAIT: d.out.vreg_state = VREG_STANDBY;
      default: d.out.vreg_state = VREG_FULL;
    endcase

    // converter: async clock only whenever the bus clock is slow or gone
    d.out.adc_async_only = in_stop || in_lp;
    d.out.adc_conv_ok = (q.mode != MODE_PARTIAL_POWERDOWN_STOP);
    if (in_lp) begin
      d.out.adc_bandgap_ok = 1'b0;
    end else if (q.mode == MODE_STANDBY_STOP) begin
      d.out.adc_bandgap_ok = lvd_en;
    end else begin
      d.out.adc_bandgap_ok = (q.mode != MODE_PARTIAL_POWERDOWN_STOP);
    end

    // comparator reference: without detect the bandgap sleeps in stop
    if (q.mode == MODE_STANDBY_STOP) begin
      d.out.analog_comparator_bandgap_ok = lvd_en;
    end else begin
      d.out.analog_comparator_bandgap_ok = (q.mode != MODE_PARTIAL_POWERDOWN_STOP);
    end

    d.out.pin_hold = (q.mode == MODE_PARTIAL_POWERDOWN_STOP);
    d.out.core_power_down = (q.mode == MODE_PARTIAL_POWERDOWN_STOP);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.gate_one <= RST_GATE_ONE;
      q.gate_two <= RST_GATE_TWO;
      q.src_one <= RST_SRC_ONE;
      q.src_two <= RST_SRC_TWO;
      q.pwr_ctrl <= RST_PWR_CTRL;
      q.out.periph_clk_en <= {RST_GATE_TWO, RST_GATE_ONE};
      q.out.cpu_clk_en <= 1'b1;
      q.out.adc_conv_ok <= 1'b1;
      q.out.adc_bandgap_ok <= 1'b1;
      q.out.analog_comparator_bandgap_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_mode = q.mode;
  assign o_pwr = q.out;

endmodule : lppg_mode_ctrl
`default_nettype wire

// ### dv/lppg_monitor.sv
// lppg_monitor: port-level assertions for the power-mode controller.
// assumes o_pwr is registered from the o_mode of the cycle before.
`timescale 1ns/1ns
`default_nettype none
module lppg_monitor
  import lppg_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire lppg_pkg::lppg_req_t i_req_kind,
  input wire logic i_reset_pin_low,
  input wire logic i_debug_mode_enable,
  input wire lppg_pkg::lppg_mode_t o_mode,
  input wire lppg_pkg::lppg_pwr_out_t o_pwr
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  logic stop_m;
  logic lp_m;
  logic dbg_req;
  logic pds_m;
  assign pds_m = (o_mode == MODE_PARTIAL_POWERDOWN_STOP);
  assign stop_m = pds_m || (o_mode == MODE_STANDBY_STOP);
  assign lp_m = (o_mode == MODE_LOWPOWER_RUN) || (o_mode == MODE_LOWPOWER_WAIT);
  assign dbg_req = i_req_valid && (o_mode == MODE_RUN) && i_debug_mode_enable;

  AST_STOP_PERIPH_OFF: assert property (stop_m |=> o_pwr.periph_clk_en == 16'h0000)
    else $error("peripheral clocks run in stop");
  AST_DBG_CLK_STOP: assert property ((o_mode == MODE_STANDBY_STOP) && i_debug_mode_enable
    |=> o_pwr.bdm_clk_en && (o_pwr.periph_clk_en == 16'h0000)) else $error("debug clock wrong");
  AST_DBG_NO_PDS: assert property (dbg_req && (i_req_kind == REQ_STOP)
    |=> o_mode == MODE_STANDBY_STOP) else $error("debug stop not standby");
  AST_DBG_NO_LP: assert property (dbg_req && (i_req_kind == REQ_LOWPOWER_RUN)
    |=> o_mode == MODE_RUN) else $error("debug low-power run entered");
  AST_LP_NO_BANDGAP: assert property (lp_m |=> !o_pwr.adc_bandgap_ok)
    else $error("bandgap conversion allowed in low power");
  AST_ASYNC_CONV_CLK: assert property ((stop_m || lp_m) |=> o_pwr.adc_async_only)
    else $error("converter not on its async clock in stop or low power");
  AST_PDS_POWER: assert property (pds_m |=> o_pwr.pin_hold && o_pwr.core_power_down
    && (o_pwr.ics_state == SRC_OFF) && (o_pwr.vreg_state == VREG_PARTIAL))
    else $error("partial powerdown outputs wrong");
  AST_PINS_FREE: assert property (!pds_m |=> !o_pwr.pin_hold)
    else $error("pins held outside partial powerdown");
  AST_PDS_HOLD: assert property (pds_m && !i_reset_pin_low |=> $stable(o_mode))
    else $error("partial powerdown left without reset pin");
endmodule : lppg_monitor

bind lppg_mode_ctrl lppg_monitor u_mon (
  .i_core_clk(i_core_clk),
  .i_arst_n(i_arst_n),
  .i_req_valid(i_req_valid),
  .i_req_kind(i_req_kind),
  .i_reset_pin_low(i_reset_pin_low),
  .i_debug_mode_enable(i_debug_mode_enable),
  .o_mode(o_mode),
  .o_pwr(o_pwr)
);
`default_nettype wire

// ### dv/lppg_core_model.sv
// lppg_core_model: core side; one-cycle mode requests and wake pulses.
// assumes the bench calls its tasks only after reset is released.
`timescale 1ns/1ns
`default_nettype none
module lppg_core_model
  import lppg_pkg::*;
(
  input wire logic i_core_clk,
  output logic o_req_valid,
  output lppg_pkg::lppg_req_t o_req_kind,
  output logic o_wake_irq,
  output logic o_reset_pin_low
);
  initial begin
    o_req_valid = 1'b0;
    o_req_kind = REQ_RUN;
    o_wake_irq = 1'b0;
    o_reset_pin_low = 1'b0;
  end
  task automatic request(input lppg_req_t k);
    @(posedge i_core_clk);
    o_req_valid <= 1'b1;
    o_req_kind <= k;
    @(posedge i_core_clk);
    o_req_valid <= 1'b0;
  endtask : request
  // wake lines are pulsed, not left high, so a later request is not cut short
  task automatic pulse(input logic pin);
    @(posedge i_core_clk);
    o_reset_pin_low <= pin;
    o_wake_irq <= !pin;
    @(posedge i_core_clk);
    o_reset_pin_low <= 1'b0;
    o_wake_irq <= 1'b0;
  endtask : pulse
endmodule : lppg_core_model
`default_nettype wire

// ### dv/testbench.sv
// testbench: random and corner-case checks of the power-mode controller.
// assumes the core model drives requests and wake lines; checker is bound.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lppg_pkg::*;
  logic clk;
  logic rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic req_valid;
  lppg_req_t req_kind;
  logic wake;
  logic pin_low;
  logic dbg;
  lppg_mode_t mode;
  lppg_pwr_out_t pwr;
  int fail_count;
  int num_checks;
  int i;
  int j;
  logic [31:0] seed;
  logic [15:0] g;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [DATA_W-1:0] rst_v [5];

  lppg_mode_ctrl u_dut (
    .i_core_clk(clk),
    .i_arst_n(rst_n),
    .i_reg_addr(addr),
    .i_reg_wdata(wdata),
    .i_reg_wr(wr),
    .i_reg_rd(rd),
    .o_reg_rdata(rdata),
    .i_req_valid(req_valid),
    .i_req_kind(req_kind),
    .i_wake_irq(wake),
    .i_reset_pin_low(pin_low),
    .i_debug_mode_enable(dbg),
    .o_mode(mode),
    .o_pwr(pwr)
  );
  lppg_core_model u_core (
    .i_core_clk(clk),
    .o_req_valid(req_valid),
    .o_req_kind(req_kind),
    .o_wake_irq(wake),
    .o_reset_pin_low(pin_low)
  );

  always #5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic lppg_src_state_t exp_ics(input logic [7:0] v);
    return (v[BIT_IREF_CLK] && v[BIT_IREF_STOP]) ? SRC_ON : SRC_STANDBY;
  endfunction : exp_ics

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic chk_mode(input lppg_mode_t e);
    chk("mode", 16'(e), 16'(mode));
  endtask : chk_mode
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", 16'(e), 16'(rdata));
  endtask : rd_reg
  // mode moves one edge after the request, the outputs one edge later
  task automatic go(input lppg_req_t k);
    u_core.request(k);
    @(posedge clk);
    @(negedge clk);
  endtask : go
  task automatic wk(input logic pin);
    u_core.pulse(pin);
    @(posedge clk);
    @(negedge clk);
  endtask : wk
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    dbg = 1'b0;
    seed = 32'habb0;
    rst_v = '{RST_GATE_ONE, RST_GATE_TWO, RST_SRC_ONE, RST_SRC_TWO, RST_PWR_CTRL};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd_reg(8'(i), rst_v[i]);
    end
    // run-mode outputs after the reset-value reads, before any register is written
    chk("rst_periph", 16'hffff, pwr.periph_clk_en);
    chk("rst_cpu", 16'h0001, 16'(pwr.cpu_clk_en));
    chk("rst_conv", 16'h0001, 16'(pwr.adc_conv_ok));
    chk("rst_async", 16'h0000, 16'(pwr.adc_async_only));
    chk("rst_analog_comparator", 16'h0001, 16'(pwr.analog_comparator_bandgap_ok));
    rd_reg(8'h3c, 8'h00);
    wr_reg(OFS_MODE_STAT, 8'hff);
    rd_reg(OFS_MODE_STAT, 8'h00);
    wr_reg(OFS_SRC_TWO, 8'h04);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      g = (i == 0) ? 16'h8001 : seed[15:0];
      wr_reg(OFS_GATE_ONE, g[7:0]);
      wr_reg(OFS_GATE_TWO, g[15:8]);
      go(REQ_LOWPOWER_RUN);
      chk("periph", g, pwr.periph_clk_en);
      chk("lp_async", 16'h0001, 16'(pwr.adc_async_only));
      chk("lp_bandgap", 16'h0000, 16'(pwr.adc_bandgap_ok));
      chk("lp_vreg", 16'(VREG_STANDBY), 16'(pwr.vreg_state));
      chk("lp_cpu", 16'h0001, 16'(pwr.cpu_clk_en));
      go(REQ_WAIT);
      chk_mode(MODE_LOWPOWER_WAIT);
      chk("periph", g, pwr.periph_clk_en);
      chk("lpw_cpu", 16'h0000, 16'(pwr.cpu_clk_en));
      wk(1'b0);
      // stop from low-power run must come back to low-power run
      go(REQ_STOP);
      chk_mode(MODE_STANDBY_STOP);
      chk("lps_periph", 16'h0000, pwr.periph_clk_en);
      wk(1'b0);
      chk_mode(MODE_LOWPOWER_RUN);
      go(REQ_RUN);
      chk_mode(MODE_RUN);
    end
    for (j = 0; j < 2; j++) begin
      @(posedge clk) dbg <= 1'(j);
      wr_reg(OFS_PWR_CTRL, (j == 1) ? 8'h01 : 8'h03);
      go(REQ_LOWPOWER_RUN);
      chk_mode(MODE_RUN);
      rd_reg(OFS_MODE_STAT, {3'b000, 1'b1, 1'(j), 3'b000});
      @(posedge clk) dbg <= 1'b0;
      wr_reg(OFS_PWR_CTRL, 8'h01);
      go(REQ_LOWPOWER_RUN);
      chk_mode(MODE_LOWPOWER_RUN);
      @(posedge clk) dbg <= 1'(j);
      wr_reg(OFS_PWR_CTRL, (j == 1) ? 8'h01 : 8'h03);
      go(REQ_WAIT);
      chk_mode(MODE_WAIT);
      wk(1'b0);
    end
    @(posedge clk) dbg <= 1'b0;
    for (i = 0; i < 8; i++) begin
      seed = (i == 0) ? 32'h1f : xs(seed);
      s1 = {6'h00, seed[1:0]};
      s2 = {6'h00, seed[3:2]};
      wr_reg(OFS_SRC_ONE, s1);
      wr_reg(OFS_SRC_TWO, s2);
      wr_reg(OFS_PWR_CTRL, {7'h00, seed[4]});
      go(REQ_STOP);
      chk_mode(MODE_STANDBY_STOP);
      chk("ics", 16'(exp_ics(s1)), 16'(pwr.ics_state));
      chk("xosc", 16'(s2[1] & s2[0]), 16'(pwr.xosc_run));
      chk("vreg", 16'(seed[4] ? VREG_FULL : VREG_STANDBY), 16'(pwr.vreg_state));
      chk("bandgap", 16'(seed[4]), 16'(pwr.adc_bandgap_ok));
      chk("analog_comparator", 16'(seed[4]), 16'(pwr.analog_comparator_bandgap_ok));
      chk("stop_async", 16'h0001, 16'(pwr.adc_async_only));
      chk("stop_cpu", 16'h0000, 16'(pwr.cpu_clk_en));
      wk(1'b0);
      chk_mode(MODE_RUN);
    end
    for (j = 0; j < 3; j++) begin
      @(posedge clk) dbg <= (j == 1);
      wr_reg(OFS_PWR_CTRL, (j == 0) ? 8'h06 : 8'h04);
      go(REQ_STOP);
      if (j < 2) begin
        chk_mode(MODE_STANDBY_STOP);
        chk("dbgclk", 16'(j == 1), 16'(pwr.bdm_clk_en));
      end else begin
        chk("xosc", 16'(s2[1] & s2[0]), 16'(pwr.xosc_run));
        chk("pds_conv", 16'h0000, 16'(pwr.adc_conv_ok));
        chk("pds_analog_comparator", 16'h0000, 16'(pwr.analog_comparator_bandgap_ok));
        chk("pds_cpu", 16'h0000, 16'(pwr.cpu_clk_en));
        wk(1'b0);
        chk_mode(MODE_PARTIAL_POWERDOWN_STOP);
      end
      wk(j == 2);
      chk_mode(MODE_RUN);
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
